/* core/pmcm_top.sv */
`timescale 1ns/1ps
`include "pmcm_defines.svh"
// Operation
// - Deep sleep stops core and system clocks.
// - In deep sleep, asynchronous peripherals are blocked from internal and external memory.
// - Deep sleep exits only on reset or an enabled pin wake.
// - Reset during deep sleep goes to full-on mode.
// - Pin wake from deep sleep goes to active mode, core state kept.
// - Writing zero to power-up bit stops clocks and drops regulator wake output.
// - In hibernate, external pins float.
// - Hibernate wakes on enabled reset or flag event, running full reset sequence.
// - Regulator wake output is high for power-up, marking a wake event.
// - Regulator control register survives hibernate; all else is cleared.
// - Start is held off until power good is reported.
// - Multiplier programmable 5 to 64, default 6.
// - Core and system clocks both derive from the input clock.
// - Four-bit system divider, divisors 1 through 15.
// - New system divider applies at the end of the current period, no lock delay.
// - Core divider codes 00..11 give 1, 2, 4, 8, changeable on the fly.
// - Clock output pin follows system clock, floating until enabled.
// - Full-on, not bypassed, is the default after power-up.
// - Active mode bypasses the multiplier, clocks run at input clock rate; the core and system dividers still divide the input clock here.
module pmcm_top
    import pmcm_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pmcm_wb_req_type wb_req_i,
    output pmcm_wb_rsp_type wb_rsp_o,
    input wire logic input_clock_tick_i,
    input wire logic reset_pin_i,
    input wire logic [GPIO_W-1:0] gpio_wake_i,
    input wire logic power_good_in_i,
    output pmcm_clk_type clk_o,
    output logic [5:0] pll_mult_o,
    output logic pll_bypass_o,
    output logic async_block_o,
    output logic core_reset_o,
    output logic pins_hiz_o,
    output logic regulator_wake_out_o,
    output logic sysclk_output_pin_o,
    output logic sysclk_output_pin_oe_o
);

    pmcm_mode_type mode_ff, nxt_mode;
    logic [31:0] vrctl_ff, nxt_vrctl;
    logic bypass_ff, nxt_bypass;
    logic [5:0] mult_ff, nxt_mult;
    logic [3:0] ssel_ff, nxt_ssel;
    logic [1:0] csel_ff, nxt_csel;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic wake_ff, nxt_wake;
    logic creset_ff, nxt_creset;

    logic wb_req;
    logic wb_wr;
    logic deep_req;
    logic pin_wake;
    logic [31:0] wmask;
    logic [31:0] wdat;

    // One request per ack: the ack flop masks a strobe that is still held
    assign wb_req = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
    assign wb_wr = wb_req & wb_req_i.we;
    assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                    {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign wdat = wb_req_i.dat & wmask;
    // Wake pins are sampled every clock; a 10 ns level spans at least two edges
    assign pin_wake = |(gpio_wake_i & vrctl_ff[`PMCM_VR_MASK_LSB +: GPIO_W]);
    assign deep_req = wb_wr && wb_req_i.adr == `PMCM_REG_PLLCTL
                      && wb_req_i.sel[1] && wb_req_i.dat[`PMCM_PLL_DEEP_BIT];

    // Mode and register state
    always_comb begin
        nxt_mode = mode_ff;
        nxt_vrctl = vrctl_ff;
        nxt_bypass = bypass_ff;
        nxt_mult = mult_ff;
        nxt_ssel = ssel_ff;
        nxt_csel = csel_ff;
        nxt_ack = wb_req;
        nxt_rdat = 32'h0000_0000;
        nxt_wake = wake_ff;
        nxt_creset = creset_ff;
        if (wb_req && !wb_req_i.we) begin
            unique case (wb_req_i.adr)
                `PMCM_REG_VRCTL: nxt_rdat = vrctl_ff;
                `PMCM_REG_PLLCTL: nxt_rdat = {25'h0, mult_ff, bypass_ff};
                `PMCM_REG_DIV: nxt_rdat = {26'h0, csel_ff, ssel_ff};
                `PMCM_REG_STATUS: nxt_rdat = {27'h0, power_good_in_i, 1'b0, mode_ff};
                default: nxt_rdat = 32'h0000_0000;
            endcase
        end
        if (wb_wr) begin
            unique case (wb_req_i.adr)
                `PMCM_REG_VRCTL: nxt_vrctl = (vrctl_ff & ~wmask) | wdat;
                `PMCM_REG_PLLCTL: begin
                    if (wb_req_i.sel[0]) begin
                        nxt_bypass = wb_req_i.dat[`PMCM_PLL_BYPASS_BIT];
                        // Out-of-range factors are refused, old value kept
                        if (wb_req_i.dat[`PMCM_PLL_MULT_LSB +: 6] >= `PMCM_PLL_MULT_MIN
                            || wb_req_i.dat[`PMCM_PLL_MULT_LSB +: 6] == 6'h00) begin
                            nxt_mult = wb_req_i.dat[`PMCM_PLL_MULT_LSB +: 6];
                        end
                    end
                end
                `PMCM_REG_DIV: begin
                    if (wb_req_i.sel[0]) begin
                        nxt_ssel = wb_req_i.dat[`PMCM_DIV_SSEL_LSB +: 4];
                        nxt_csel = wb_req_i.dat[`PMCM_DIV_CSEL_LSB +: 2];
                    end
                end
                default: ;
            endcase
        end
        unique case (mode_ff)
            PMCM_PWRUP: begin
                nxt_wake = 1'b1;
                nxt_creset = 1'b1;
                if (power_good_in_i) begin
                    nxt_mode = PMCM_FULL;
                    nxt_creset = 1'b0;
                end
            end
            PMCM_FULL, PMCM_ACTIVE: begin
                if (!nxt_vrctl[`PMCM_VR_PWRUP_BIT]) begin
                    nxt_mode = PMCM_HIB;
                    nxt_wake = 1'b0;
                end else if (deep_req) begin
                    nxt_mode = PMCM_DEEP;
                end else begin
                    nxt_mode = nxt_bypass ? PMCM_ACTIVE : PMCM_FULL;
                end
            end
            PMCM_DEEP: begin
                // Bus writes cannot end deep sleep, only the two wake sources
                if (reset_pin_i) begin
                    nxt_mode = PMCM_FULL;
                    nxt_bypass = 1'b0;
                end else if (pin_wake) begin
                    // Core is not reset, so execution resumes in place
                    nxt_mode = PMCM_ACTIVE;
                    nxt_bypass = 1'b1;
                end
            end
            PMCM_HIB: begin
                // Enables come from the stored register, not from a write in flight
                if ((reset_pin_i && vrctl_ff[`PMCM_VR_RSTWAKE_BIT])
                    || (pin_wake && vrctl_ff[`PMCM_VR_FLAGWAKE_BIT])) begin
                    nxt_mode = PMCM_PWRUP;
                    nxt_wake = 1'b1;
                    nxt_creset = 1'b1;
                    nxt_vrctl[`PMCM_VR_PWRUP_BIT] = 1'b1;
                    // Everything except regulator control is lost
                    nxt_bypass = 1'b0;
                    nxt_mult = `PMCM_PLL_MULT_RESET;
                    nxt_ssel = `PMCM_DIV_SSEL_RESET;
                    nxt_csel = `PMCM_DIV_CSEL_RESET;
                end
            end
            default: nxt_mode = PMCM_PWRUP;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= PMCM_PWRUP;
            vrctl_ff <= `PMCM_VR_RESET;
            bypass_ff <= 1'b0;
            mult_ff <= `PMCM_PLL_MULT_RESET;
            ssel_ff <= `PMCM_DIV_SSEL_RESET;
            csel_ff <= `PMCM_DIV_CSEL_RESET;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            wake_ff <= 1'b1;
            creset_ff <= 1'b1;
        end else begin
            mode_ff <= nxt_mode;
            vrctl_ff <= nxt_vrctl;
            bypass_ff <= nxt_bypass;
            mult_ff <= nxt_mult;
            ssel_ff <= nxt_ssel;
            csel_ff <= nxt_csel;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            wake_ff <= nxt_wake;
            creset_ff <= nxt_creset;
        end
    end

    // Clock dividers. A period in progress always completes with its old
    // ratio, so a divider change never yields a short pulse.
    logic [3:0] scnt_ff, nxt_scnt;
    logic [3:0] sdiv_ff, nxt_sdiv;
    logic [7:0] ccnt_ff, nxt_ccnt;
    logic [7:0] cdiv_ff, nxt_cdiv;
    logic core_en_ff, nxt_core_en;
    logic sys_en_ff, nxt_sys_en;
    logic pin_ff, nxt_pin;
    logic tick;
    logic run;
    logic [3:0] ssel_eff;

    // Full-on uses the multiplied rate (clk_i), active uses the input clock
    assign tick = (mode_ff == PMCM_ACTIVE) ? input_clock_tick_i : 1'b1;
    assign run = (mode_ff == PMCM_FULL) || (mode_ff == PMCM_ACTIVE);
    // Divisor 0 is not legal; treated as 1 so the clock never stops
    assign ssel_eff = (ssel_ff == 4'h0) ? 4'h1 : ssel_ff;

    always_comb begin
        nxt_scnt = scnt_ff;
        nxt_sdiv = sdiv_ff;
        nxt_ccnt = ccnt_ff;
        nxt_cdiv = cdiv_ff;
        nxt_sys_en = 1'b0;
        nxt_core_en = 1'b0;
        nxt_pin = 1'b0;
        // Stopped modes restart the count, so the first period after a wake is whole
        if (!run) begin
            nxt_scnt = 4'h0;
            nxt_ccnt = 8'h00;
        end else if (tick) begin
            if (scnt_ff >= sdiv_ff - 4'h1) begin
                nxt_scnt = 4'h0;
                nxt_sys_en = 1'b1;
                nxt_pin = 1'b1;
                nxt_sdiv = ssel_eff;
            end else begin
                nxt_scnt = scnt_ff + 4'h1;
            end
            if (ccnt_ff >= cdiv_ff - 8'h01) begin
                nxt_ccnt = 8'h00;
                nxt_core_en = 1'b1;
                nxt_cdiv = 8'h01 << csel_ff;
            end else begin
                nxt_ccnt = ccnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scnt_ff <= 4'h0;
            sdiv_ff <= `PMCM_DIV_SSEL_RESET;
            ccnt_ff <= 8'h00;
            cdiv_ff <= 8'h01;
            sys_en_ff <= 1'b0;
            core_en_ff <= 1'b0;
            pin_ff <= 1'b0;
        end else begin
            scnt_ff <= nxt_scnt;
            sdiv_ff <= nxt_sdiv;
            ccnt_ff <= nxt_ccnt;
            cdiv_ff <= nxt_cdiv;
            sys_en_ff <= nxt_sys_en;
            core_en_ff <= nxt_core_en;
            pin_ff <= nxt_pin;
        end
    end

    // Status outputs, each registered
    logic block_ff, nxt_block;
    logic hiz_ff, nxt_hiz;
    logic pin_oe_ff, nxt_pin_oe;

    // Decoded from the next mode so they switch on the same edge as the mode
    always_comb begin
        nxt_block = (nxt_mode == PMCM_DEEP);
        nxt_hiz = (nxt_mode == PMCM_HIB);
        nxt_pin_oe = nxt_vrctl[`PMCM_VR_CLKPIN_BIT] && (nxt_mode != PMCM_HIB);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_ff <= 1'b0;
            hiz_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            block_ff <= nxt_block;
            hiz_ff <= nxt_hiz;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    assign wb_rsp_o.ack = ack_ff;
    assign wb_rsp_o.dat = rdat_ff;
    assign clk_o.core_en = core_en_ff;
    assign clk_o.sys_en = sys_en_ff;
    assign pll_mult_o = mult_ff;
    assign pll_bypass_o = bypass_ff;
    assign async_block_o = block_ff;
    assign core_reset_o = creset_ff;
    assign pins_hiz_o = hiz_ff;
    assign regulator_wake_out_o = wake_ff;
    assign sysclk_output_pin_o = pin_ff;
    assign sysclk_output_pin_oe_o = pin_oe_ff;

endmodule

/* core/pmcm_defines.svh */
`ifndef PMCM_DEFINES_SVH
`define PMCM_DEFINES_SVH

// Register byte offsets
`define PMCM_REG_VRCTL 4'h0
`define PMCM_REG_PLLCTL 4'h4
`define PMCM_REG_DIV 4'h8
`define PMCM_REG_STATUS 4'hC

// Regulator control fields
`define PMCM_VR_PWRUP_BIT 0
`define PMCM_VR_CLKPIN_BIT 1
`define PMCM_VR_RSTWAKE_BIT 2
`define PMCM_VR_FLAGWAKE_BIT 3
`define PMCM_VR_MASK_LSB 8
`define PMCM_VR_RESET 32'h0000_0005

// PLL control fields
`define PMCM_PLL_BYPASS_BIT 0
`define PMCM_PLL_MULT_LSB 1
`define PMCM_PLL_DEEP_BIT 8
`define PMCM_PLL_MULT_RESET 6'h06
`define PMCM_PLL_MULT_MIN 6'h05

// Divider fields
`define PMCM_DIV_SSEL_LSB 0
`define PMCM_DIV_CSEL_LSB 4
`define PMCM_DIV_SSEL_RESET 4'h5
`define PMCM_DIV_CSEL_RESET 2'h0

`endif

/* core/pmcm_pkg.sv */
package pmcm_pkg;

    typedef enum logic [2:0] {
        PMCM_PWRUP = 3'b000,
        PMCM_FULL = 3'b001,
        PMCM_ACTIVE = 3'b010,
        PMCM_DEEP = 3'b011,
        PMCM_HIB = 3'b100
    } pmcm_mode_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } pmcm_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pmcm_wb_rsp_type;

    typedef struct packed {
        logic core_en;
        logic sys_en;
    } pmcm_clk_type;

endpackage

/* testbench/pmcm_partner.sv */
`timescale 1ns/1ps
module pmcm_partner #(
    parameter int PG_DLY = 20,
    parameter int HOLD = 3
) (
    input wire logic clk_i,
    input wire logic regulator_wake_out_i,
    input wire logic [8:0] wake_cmd_i,
    output logic power_good_in_o = 1'b0,
    output logic reset_pin_o,
    output logic [7:0] gpio_wake_o
);
    int pg_cnt = 0;
    int hold_cnt = 0;
    logic [8:0] pat = 9'h000;
    always @(posedge clk_i) begin
        // Supply collapses at once but ramps slowly, so power good lags the request
        pg_cnt <= !regulator_wake_out_i ? 0 : (pg_cnt < PG_DLY ? pg_cnt + 1 : pg_cnt);
        power_good_in_o <= regulator_wake_out_i && pg_cnt >= PG_DLY;
        if (wake_cmd_i != 9'h000) begin
            pat <= wake_cmd_i;
            hold_cnt <= HOLD;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end
    // Three cycles is 12 ns, just over the minimum wake level time
    assign {reset_pin_o, gpio_wake_o} = (hold_cnt > 0) ? pat : 9'h000;
endmodule

/* testbench/pmcm_monitor.sv */
`timescale 1ns/1ps
module pmcm_monitor
    import pmcm_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_i,
    input wire logic [GPIO_W-1:0] gpio_wake_i,
    input wire logic power_good_in_i,
    input wire pmcm_clk_type clk_o,
    input wire logic [5:0] pll_mult_o,
    input wire logic pll_bypass_o,
    input wire logic async_block_o,
    input wire logic core_reset_o,
    input wire logic pins_hiz_o,
    input wire logic regulator_wake_out_o,
    input wire logic sysclk_output_pin_o,
    input wire logic sysclk_output_pin_oe_o
);
    logic [7:0] sys_gap_ff, nxt_sys_gap, core_gap_ff, nxt_core_gap;
    logic run_full;
    assign run_full = !core_reset_o && !async_block_o && !pins_hiz_o && !pll_bypass_o;
    always_comb begin
        nxt_sys_gap = (rst_i || clk_o.sys_en || !run_full) ? 8'h00 : sys_gap_ff + 8'h01;
        nxt_core_gap = (rst_i || clk_o.core_en || !run_full) ? 8'h00 : core_gap_ff + 8'h01;
    end
    always_ff @(posedge clk_i) begin
        sys_gap_ff <= nxt_sys_gap;
        core_gap_ff <= nxt_core_gap;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_deep_clk_stop: assert property (async_block_o && $past(async_block_o) |->
        !clk_o.core_en && !clk_o.sys_en) else $error("clock enable seen in deep sleep");
    a_deep_stays: assert property ((!reset_pin_i && gpio_wake_i == '0)[*3] ##0 async_block_o
        |=> async_block_o) else $error("deep sleep left without wake");
    a_reset_exit: assert property (async_block_o && reset_pin_i |-> ##[1:3] !async_block_o)
        else $error("reset pin did not end deep sleep");
    a_hib_reg_off: assert property (pins_hiz_o && $past(pins_hiz_o) |-> !regulator_wake_out_o)
        else $error("regulator wake high in hibernate");
    a_wake_resets: assert property ($rose(regulator_wake_out_o) |-> ##[0:1] core_reset_o)
        else $error("wake without core reset");
    a_pg_gate: assert property (core_reset_o && !power_good_in_i |=> core_reset_o)
        else $error("started without power good");
    a_mult_legal: assert property (pll_mult_o == 6'h00 || pll_mult_o >= 6'h05)
        else $error("multiplier out of range");
    a_pin_follow: assert property (sysclk_output_pin_o == clk_o.sys_en)
        else $error("clock pin differs from system clock");
    a_sys_bound: assert property (sys_gap_ff <= 8'h0F)
        else $error("system clock period above 15");
    a_core_bound: assert property (core_gap_ff <= 8'h08)
        else $error("core clock period above 8");
    a_hib_pin_off: assert property (pins_hiz_o |-> !sysclk_output_pin_oe_o)
        else $error("clock pin driven in hibernate");
    c_deep: cover property ($rose(async_block_o));
    c_hib: cover property ($rose(pins_hiz_o));
    c_pin_wake: cover property ($fell(async_block_o) ##1 pll_bypass_o);
endmodule
bind pmcm_top pmcm_monitor #(.GPIO_W(GPIO_W)) u_mon (.clk_i, .rst_i, .reset_pin_i, .gpio_wake_i,
    .power_good_in_i, .clk_o, .pll_mult_o, .pll_bypass_o, .async_block_o, .core_reset_o,
    .pins_hiz_o, .regulator_wake_out_o, .sysclk_output_pin_o,
    .sysclk_output_pin_oe_o);

/* testbench/power_mode_clock_manager_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module power_mode_clock_manager_tb_top;
    import pmcm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic input_clock_tick_i = 1'b0;
    logic tick_en = 1'b0;
    logic [8:0] wake_cmd = 9'h000;
    pmcm_wb_req_type wb_req_i = '0;
    pmcm_wb_rsp_type wb_rsp_o;
    pmcm_clk_type clk_o;
    logic [5:0] pll_mult_o;
    logic pll_bypass_o, async_block_o, core_reset_o, pins_hiz_o, regulator_wake_out_o;
    logic sysclk_output_pin_o, sysclk_output_pin_oe_o, power_good_in_i, reset_pin_i;
    logic [7:0] gpio_wake_i;
    logic [31:0] rd;
    logic [3:0] st [4] = '{4'h1, 4'h2, 4'h6, 4'hF};
    logic [5:0] mw [3] = '{6'h04, 6'h00, 6'h05};
    logic [5:0] me [3] = '{6'h06, 6'h00, 6'h05};
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    pmcm_top #(.GPIO_W(8)) uut (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .input_clock_tick_i,
        .reset_pin_i, .gpio_wake_i, .power_good_in_i, .clk_o, .pll_mult_o, .pll_bypass_o,
        .async_block_o, .core_reset_o, .pins_hiz_o, .regulator_wake_out_o,
        .sysclk_output_pin_o, .sysclk_output_pin_oe_o);
    pmcm_partner u_far (.clk_i, .regulator_wake_out_i(regulator_wake_out_o),
        .wake_cmd_i(wake_cmd), .power_good_in_o(power_good_in_i), .reset_pin_o(reset_pin_i),
        .gpio_wake_o(gpio_wake_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        input_clock_tick_i <= tick_en && (cyc % 3 == 0);
        if (cyc > 20000) begin
            err_count++;
            end_sim;
        end
    end
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        wb_req_i <= '{1'b1, 1'b1, w, 4'hF, a, d};
        @(posedge clk_i);
        while (wb_rsp_o.ack !== 1'b1) @(posedge clk_i);
        rd = wb_rsp_o.dat;
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wake(input logic [8:0] p);
        wake_cmd <= p;
        @(posedge clk_i);
        wake_cmd <= 9'h000;
        @(posedge clk_i);
    endtask
    // Two periods are timed since a new ratio only lands at a period end
    task automatic gap(input logic s, input int e);
        int n;
        repeat (2) begin
            while ((s ? clk_o.sys_en : clk_o.core_en) !== 1'b1) @(posedge clk_i);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while ((s ? clk_o.sys_en : clk_o.core_en) !== 1'b1);
        end
        `CHK(n, e)
    endtask
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rc(4'hC, 32'h0);
        while (core_reset_o !== 1'b0) @(posedge clk_i);
        rc(4'hC, 32'h11);
        rc(4'h0, 32'h5);
        rc(4'h4, 32'hC);
        rc(4'h8, 32'h5);
        rc(4'h6, 32'h0);
        `CHK(sysclk_output_pin_oe_o, 1'b0)
        gap(1'b1, 5);
        wb(1'b1, 4'h0, 32'h107);
        `CHK(sysclk_output_pin_oe_o, 1'b1)
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 4'h8, {26'h0, i[1:0], st[i]});
            gap(1'b1, st[i]);
            gap(1'b0, 1 << i);
        end
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, 4'h4, {25'h0, mw[k], 1'b0});
            `CHK(pll_mult_o, me[k])
        end
        tick_en <= 1'b1;
        wb(1'b1, 4'h4, 32'hD);
        wb(1'b1, 4'h8, 32'h2);
        gap(1'b1, 6);
        gap(1'b0, 3);
        rc(4'hC, 32'h12);
        wb(1'b1, 4'h4, 32'h10C);
        while (async_block_o !== 1'b1) @(posedge clk_i);
        rc(4'hC, 32'h13);
        wake(9'h002);
        repeat (6) @(posedge clk_i);
        `CHK(async_block_o, 1'b1)
        wake(9'h001);
        while (async_block_o !== 1'b0) @(posedge clk_i);
        rc(4'hC, 32'h12);
        `CHK(core_reset_o, 1'b0)
        wb(1'b1, 4'h4, 32'h10D);
        while (async_block_o !== 1'b1) @(posedge clk_i);
        wake(9'h100);
        while (async_block_o !== 1'b0) @(posedge clk_i);
        rc(4'hC, 32'h11);
        `CHK(pll_bypass_o, 1'b0)
        wb(1'b1, 4'h0, 32'h10E);
        `CHK(regulator_wake_out_o, 1'b0)
        `CHK(pins_hiz_o, 1'b1)
        `CHK(sysclk_output_pin_oe_o, 1'b0)
        wake(9'h100);
        while (regulator_wake_out_o !== 1'b1) @(posedge clk_i);
        `CHK(core_reset_o, 1'b1)
        while (core_reset_o !== 1'b0) @(posedge clk_i);
        rc(4'h0, 32'h10F);
        rc(4'h8, 32'h5);
        wb(1'b1, 4'h0, 32'h10A);
        wake(9'h100);
        repeat (6) @(posedge clk_i);
        `CHK(pins_hiz_o, 1'b1)
        wake(9'h001);
        while (regulator_wake_out_o !== 1'b1) @(posedge clk_i);
        while (core_reset_o !== 1'b0) @(posedge clk_i);
        rc(4'h0, 32'h10B);
        end_sim;
    end
endmodule
